/* hw/sds_params.svh */
`ifndef SDS_PARAMS_SVH
`define SDS_PARAMS_SVH

// Register byte addresses
`define SDS_ADDR_TXA_START 32'h4000_C810
`define SDS_ADDR_STATUS 32'h4000_C82C
`define SDS_ADDR_CONTROL 32'h4000_C830
`define SDS_ADDR_CONFIG 32'h4000_C840

// Status register fields
`define SDS_ST_RX_A_ACT 0
`define SDS_ST_RX_B_ACT 1
`define SDS_ST_TX_A_ACT 2
`define SDS_ST_TX_B_ACT 3
`define SDS_ST_OVF_LO 4
`define SDS_ST_PAR_LO 6
`define SDS_ST_FRM_LO 8
`define SDS_ST_SAVED_LO 10
`define SDS_STATUS_RESET 32'h0000_0000

// Control register fields
`define SDS_CT_RX_A_LOAD 0
`define SDS_CT_RX_B_LOAD 1
`define SDS_CT_TX_A_LOAD 2
`define SDS_CT_TX_B_LOAD 3
`define SDS_CT_RX_RESET 4
`define SDS_CT_TX_RESET 5

// Configuration register fields
`define SDS_CF_UART 0
`define SDS_CF_SPI_SLAVE 1

// Saved-count codes
`define SDS_SAVED_NONE 3'h0
`define SDS_SAVED_ONCE 2'h1
`define SDS_SAVED_MANY 2'h3

// Bus responses
`define SDS_RESP_OKAY 2'h0
`define SDS_RESP_SLVERR 2'h2

`endif

/* hw/sds_pkg.sv */
package sds_pkg;

    // Pointers of one buffer, from the address and count logic
    typedef struct packed {
        logic [13:0] start;
        logic [13:0] end_addr;
        logic [13:0] count;
    } sds_buf_ptr_s;

    // One byte taken from the receive FIFO with its error marks
    typedef struct packed {
        logic pop;
        logic frame_err;
        logic parity_err;
        logic overrun;
    } sds_rx_pop_s;

    // Whole state of the block except the reset release flops
    typedef struct packed {
        logic ssel_meta;
        logic ssel_sync;
        logic ssel_prev;
        logic [1:0] rx_ld;
        logic [1:0] tx_ld;
        logic rx_cur_b;
        logic tx_cur_b;
        logic [1:0] frm;
        logic [1:0] par;
        logic [1:0] ovf;
        logic [2:0] saved;
        logic [13:0] saved_cnt;
        logic [13:0] txa_start;
        logic uart_mode;
        logic spi_slave;
        logic aw_hold;
        logic [31:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sds_state_s;

endpackage

/* hw/sds_dma_status.sv */
`timescale 1ns/1ns
`include "sds_params.svh"

module sds_dma_status
    import sds_pkg::*;
#(
    parameter bit CONTROLLER_ONE = 1'b1,
    parameter int CNT_W = 14
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic slave_select_n,
    input wire sds_rx_pop_s rx_pop,
    input wire sds_buf_ptr_s rx_ptr_a,
    input wire sds_buf_ptr_s rx_ptr_b,
    input wire sds_buf_ptr_s tx_ptr_b,
    input wire logic [13:0] tx_count,
    input wire logic [13:0] tx_end_a,
    output logic [1:0] rx_active,
    output logic [1:0] tx_active,
    output logic [13:0] rx_count_capture,
    output logic [13:0] tx_buffer_a_start
);

    //--------------------------------------------------------------
    // Elaboration checks
    //--------------------------------------------------------------
    if (CNT_W != 14) begin : g_bad_width
        $error("Count width must match the 14-bit pointer fields");
    end

    //--------------------------------------------------------------
    // Reset release
    //--------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    // True once a buffer's next address lies beyond its last byte
    function automatic logic past_end(input logic [13:0] start,
                                      input logic [13:0] cnt,
                                      input logic [13:0] last);
        logic [14:0] nxt;
        nxt = {1'b0, start} + {1'b0, cnt};
        return nxt > {1'b0, last};
    endfunction

    // Merge each byte lane of write data under its strobe
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    sds_state_s s_q;
    sds_state_s s_d;

    logic [31:0] status_word;
    logic [31:0] cfg_word;
    logic [31:0] txs_word;
    logic [31:0] txs_new;
    logic [31:0] wr_val;
    logic do_write;
    logic ctl_wr;
    logic rx_rst;
    logic tx_rst;
    logic [1:0] rx_load;
    logic [1:0] tx_load;
    logic [1:0] rx_unl;
    logic [1:0] tx_unl;
    logic err_en;
    logic ssel_fall;
    logic rx_any;
    logic [1:0] pop_sel;

    //--------------------------------------------------------------
    // Status word and plain outputs
    //--------------------------------------------------------------
    // Active means loaded and selected as current
    assign rx_active = {s_q.rx_ld[1] & s_q.rx_cur_b,
                        s_q.rx_ld[0] & ~s_q.rx_cur_b};
    assign tx_active = {s_q.tx_ld[1] & s_q.tx_cur_b,
                        s_q.tx_ld[0] & ~s_q.tx_cur_b};
    assign rx_any = |rx_active;

    // Read-only status image, upper bits zero
    always_comb begin
        status_word = `SDS_STATUS_RESET;
        status_word[`SDS_ST_RX_A_ACT] = rx_active[0];
        status_word[`SDS_ST_RX_B_ACT] = rx_active[1];
        status_word[`SDS_ST_TX_A_ACT] = tx_active[0];
        status_word[`SDS_ST_TX_B_ACT] = tx_active[1];
        status_word[`SDS_ST_OVF_LO +: 2] = s_q.ovf;
        status_word[`SDS_ST_PAR_LO +: 2] = s_q.par;
        status_word[`SDS_ST_FRM_LO +: 2] = s_q.frm;
        status_word[`SDS_ST_SAVED_LO +: 3] = s_q.saved;
    end

    assign cfg_word = {30'h0000_0000, s_q.spi_slave, s_q.uart_mode};
    assign txs_word = {18'h0_0000, s_q.txa_start};
    assign txs_new = merge(txs_word, s_q.wdata, s_q.wstrb);
    assign rx_count_capture = s_q.saved_cnt;
    assign tx_buffer_a_start = s_q.txa_start;

    //--------------------------------------------------------------
    // Bus handshakes
    //--------------------------------------------------------------
    assign s_axi_awready = ~s_q.aw_hold & ~s_q.bvalid;
    assign s_axi_wready = ~s_q.w_hold & ~s_q.bvalid;
    assign s_axi_arready = ~s_q.rvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    //--------------------------------------------------------------
    // Decoded events of this cycle
    //--------------------------------------------------------------
    assign do_write = s_q.aw_hold & s_q.w_hold & ~s_q.bvalid;
    assign wr_val = s_q.wdata;
    assign ctl_wr = do_write & (s_q.awaddr == `SDS_ADDR_CONTROL)
                    & s_q.wstrb[0];
    assign rx_rst = ctl_wr & wr_val[`SDS_CT_RX_RESET];
    assign tx_rst = ctl_wr & wr_val[`SDS_CT_TX_RESET];
    assign rx_load = {2{ctl_wr}} & wr_val[`SDS_CT_RX_A_LOAD +: 2];
    assign tx_load = {2{ctl_wr}} & wr_val[`SDS_CT_TX_A_LOAD +: 2];

    // Active buffer runs past its end
    assign rx_unl[0] = rx_active[0] & past_end(rx_ptr_a.start,
                       rx_ptr_a.count, rx_ptr_a.end_addr);
    assign rx_unl[1] = rx_active[1] & past_end(rx_ptr_b.start,
                       rx_ptr_b.count, rx_ptr_b.end_addr);
    assign tx_unl[0] = tx_active[0] & past_end(s_q.txa_start,
                       tx_count, tx_end_a);
    assign tx_unl[1] = tx_active[1] & past_end(tx_ptr_b.start,
                       tx_count, tx_ptr_b.end_addr);

    assign err_en = CONTROLLER_ONE & s_q.uart_mode;
    assign ssel_fall = s_q.ssel_sync & ~s_q.ssel_prev & s_q.spi_slave;
    assign pop_sel = {2{rx_pop.pop}} & rx_active;

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Slave select synchroniser and edge memory
        s_d.ssel_meta = slave_select_n;
        s_d.ssel_sync = s_q.ssel_meta;
        s_d.ssel_prev = s_q.ssel_sync;

        // Unload and move to the other buffer
        s_d.rx_ld = s_q.rx_ld & ~rx_unl;
        if (|rx_unl) begin
            s_d.rx_cur_b = ~s_q.rx_cur_b;
        end
        s_d.tx_ld = s_q.tx_ld & ~tx_unl;
        if (|tx_unl) begin
            s_d.tx_cur_b = ~s_q.tx_cur_b;
        end

        // Receive reset and loads
        if (rx_rst) begin
            s_d.rx_ld = 2'h0;
            s_d.rx_cur_b = 1'b0;
            s_d.frm = 2'h0;
            s_d.par = 2'h0;
            s_d.ovf = 2'h0;
            s_d.saved = `SDS_SAVED_NONE;
        end
        if (|rx_load) begin
            s_d.saved = `SDS_SAVED_NONE;
            if (s_d.rx_ld == 2'h0) begin
                s_d.rx_cur_b = rx_load == 2'h2;
            end
            s_d.frm = s_d.frm & ~rx_load;
            s_d.par = s_d.par & ~rx_load;
            s_d.ovf = s_d.ovf & ~rx_load;
            s_d.rx_ld = s_d.rx_ld | rx_load;
        end

        // Transmit reset and loads
        if (tx_rst) begin
            s_d.tx_ld = 2'h0;
            s_d.tx_cur_b = 1'b0;
        end
        if (|tx_load) begin
            if (s_d.tx_ld == 2'h0) begin
                s_d.tx_cur_b = tx_load == 2'h2;
            end
            s_d.tx_ld = s_d.tx_ld | tx_load;
        end

        // Error marks land on the buffer draining the FIFO
        if (err_en & rx_pop.frame_err) begin
            s_d.frm = s_d.frm | pop_sel;
        end
        if (err_en & rx_pop.parity_err) begin
            s_d.par = s_d.par | pop_sel;
        end
        if (rx_pop.overrun) begin
            s_d.ovf = s_d.ovf | pop_sel;
        end

        // Count capture on slave select deassertion
        if (ssel_fall & rx_any) begin
            s_d.saved_cnt = s_q.rx_cur_b ? rx_ptr_b.count
                                         : rx_ptr_a.count;
            if (s_q.saved == `SDS_SAVED_NONE) begin
                s_d.saved = {`SDS_SAVED_ONCE, s_q.rx_cur_b};
            end else begin
                s_d.saved = {`SDS_SAVED_MANY, s_q.rx_cur_b};
            end
        end

        // Write channel capture
        if (s_axi_awvalid & s_axi_awready) begin
            s_d.aw_hold = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            s_d.w_hold = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end

        // Write execution; status is not writable
        if (do_write) begin
            s_d.aw_hold = 1'b0;
            s_d.w_hold = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `SDS_RESP_OKAY;
            case (s_q.awaddr)
                `SDS_ADDR_TXA_START: begin
                    s_d.txa_start = txs_new[13:0];
                end
                `SDS_ADDR_CONFIG: begin
                    s_d.uart_mode = s_q.wstrb[0]
                        ? wr_val[`SDS_CF_UART] : s_q.uart_mode;
                    s_d.spi_slave = s_q.wstrb[0]
                        ? wr_val[`SDS_CF_SPI_SLAVE] : s_q.spi_slave;
                end
                `SDS_ADDR_CONTROL, `SDS_ADDR_STATUS: begin
                    s_d.bresp = `SDS_RESP_OKAY;
                end
                default: begin
                    s_d.bresp = `SDS_RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid & s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Reads have no side effect on any flag
        if (s_axi_arvalid & s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `SDS_RESP_OKAY;
            case (s_axi_araddr)
                `SDS_ADDR_STATUS: s_d.rdata = status_word;
                `SDS_ADDR_CONTROL: begin
                    s_d.rdata = {28'h000_0000, s_q.tx_ld, s_q.rx_ld};
                end
                `SDS_ADDR_TXA_START: s_d.rdata = txs_word;
                `SDS_ADDR_CONFIG: s_d.rdata = cfg_word;
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = `SDS_RESP_SLVERR;
                end
            endcase
        end else if (s_q.rvalid & s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    //--------------------------------------------------------------
    // State register
    //--------------------------------------------------------------
    // Everything clears to zero, status included
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_wr_taken;
        s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    endsequence
    sequence seq_wr_resp;
        ##2 s_axi_bvalid;
    endsequence

    chk_write_resp: assert property (seq_wr_taken |-> seq_wr_resp)
        else $error("Write response not two cycles after request");
    chk_saved_codes: assert property (
        !(s_q.saved inside {3'h1, 3'h4, 3'h5}))
        else $error("Reserved saved-count code seen");
    chk_saved_once: assert property (
        ssel_fall & rx_any & !(|rx_load) & !rx_rst
        & s_q.saved == 3'h0 |=> s_q.saved == {2'h1, $past(s_q.rx_cur_b)})
        else $error("First deassertion code wrong");
    chk_saved_many: assert property (
        ssel_fall & rx_any & s_q.saved != 3'h0
        |=> s_q.saved == {2'h3, $past(s_q.rx_cur_b)})
        else $error("Repeat deassertion code wrong");
    chk_saved_clear: assert property (
        (rx_rst | (|rx_load)) & !ssel_fall |=> s_q.saved == 3'h0)
        else $error("Saved-count not cleared");
    chk_frame_set: assert property (
        rx_pop.pop & rx_pop.frame_err & err_en & rx_active[1]
        |=> s_q.frm[1] & status_word[9])
        else $error("Frame flag B not set");
    chk_parity_set: assert property (
        rx_pop.pop & rx_pop.parity_err & err_en & rx_active[0]
        |=> s_q.par[0] & status_word[6])
        else $error("Parity flag A not set");
    chk_uart_gate: assert property (
        !err_en & !rx_rst & !(|rx_load) |=> $stable(s_q.frm))
        else $error("Frame flag moved outside UART mode");
    chk_flag_clear: assert property (
        rx_rst & !rx_pop.pop |=> (s_q.frm | s_q.par | s_q.ovf) == 2'h0)
        else $error("Error flags survive receive reset");
    chk_ovf_set: assert property (
        rx_pop.pop & rx_pop.overrun & rx_active[1]
        |=> status_word[5])
        else $error("Overrun flag B not set");
    chk_tx_onehot: assert property (
        tx_active != 2'h3 && status_word[3:2] == tx_active)
        else $error("Transmit activity bits wrong");
    chk_load_both: assert property (
        rx_load == 2'h3 && s_q.rx_ld == 2'h0 && !rx_rst
        |=> rx_active == 2'h1 ##0 status_word[0])
        else $error("Buffer A not first after double load");
    chk_unload: assert property (
        rx_unl[0] & !rx_load[0] |=> !s_q.rx_ld[0])
        else $error("Receive A not unloaded past its end");

endmodule

/* hw/sds_unused_guard.sv */
`timescale 1ns/1ns

/* verification/sds_fifo_model.sv */
`timescale 1ns/1ns

// ----------------------------------------
// Receive FIFO and buffer pointer model
// ----------------------------------------
module sds_fifo_model
    import sds_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [1:0] rx_active,
    input wire sds_rx_pop_s want,
    input wire logic [13:0] end_a,
    input wire logic [13:0] end_b,
    output sds_rx_pop_s rx_pop,
    output sds_buf_ptr_s rx_ptr_a,
    output sds_buf_ptr_s rx_ptr_b
);
    logic [13:0] cnt_a_q;
    logic [13:0] cnt_b_q;

    // FIFO hands a byte, with its marks, only to an active buffer
    assign rx_pop = (|rx_active) ? want : '0;

    // Byte counts run only while the buffer is active, so a reload
    // starts from zero and cannot unload at once
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_a_q <= '0;
            cnt_b_q <= '0;
        end else begin
            cnt_a_q <= rx_active[0] ? cnt_a_q + 14'(rx_pop.pop) : '0;
            cnt_b_q <= rx_active[1] ? cnt_b_q + 14'(rx_pop.pop) : '0;
        end
    end

    // Buffers start at zero; end addresses come from the bench
    assign rx_ptr_a = '{start: 14'h0000, end_addr: end_a, count: cnt_a_q};
    assign rx_ptr_b = '{start: 14'h0000, end_addr: end_b, count: cnt_b_q};
endmodule

/* verification/serial_dma_status_tracking_tb_top.sv */
`timescale 1ns/1ns
`include "sds_params.svh"

module serial_dma_status_tracking_tb_top
    import sds_pkg::*;
;
    logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, ssel_n;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rx_active, tx_active;
    logic [13:0] end_a, cnt_cap, txa_start;
    sds_rx_pop_s want, rx_pop;
    sds_buf_ptr_s ptr_a, ptr_b;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int miscompares = 0;
    int n_tests = 0;
    integer seed = 59;
    logic [31:0] rv;

    // ----------------------------------------
    // Clock, design and far side
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    sds_dma_status i_dut (.clk(clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .slave_select_n(ssel_n), .rx_pop(rx_pop),
        .rx_ptr_a(ptr_a), .rx_ptr_b(ptr_b),
        .tx_ptr_b('{start: 14'h0000, end_addr: 14'h3fff, count: 14'h0000}),
        .tx_count(14'h0000), .tx_end_a(end_a), .rx_active(rx_active),
        .tx_active(tx_active), .rx_count_capture(cnt_cap),
        .tx_buffer_a_start(txa_start));

    sds_fifo_model i_fifo (.clk(clk), .arst_n(arst_n),
        .rx_active(rx_active), .want(want), .end_a(14'h0002),
        .end_b(14'h3fff), .rx_pop(rx_pop), .rx_ptr_a(ptr_a),
        .rx_ptr_b(ptr_b));

    // ----------------------------------------
    // Comparison, verdict and bus tasks
    // ----------------------------------------
    task check(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task summarize();
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
        bit ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bq.push_back(e);
        while (!(ad && wd)) begin
            @(posedge clk);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [31:0] a, input logic [33:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rq.push_back(e);
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // Status read with an OKAY answer
    task rd_st(input logic [31:0] v);
        rd(`SDS_ADDR_STATUS, {`SDS_RESP_OKAY, v});
    endtask

    // One byte offered by the receive FIFO
    task pop(input sds_rx_pop_s p);
        want <= p;
        @(posedge clk);
        want <= '0;
        repeat (2) @(posedge clk);
    endtask

    // One deassertion and reassertion of slave select
    task ss();
        ssel_n <= 1'b1;
        repeat (8) @(posedge clk);
        ssel_n <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // Answers are compared against the oldest note
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
            check({rresp, rdata}, rq.pop_front());
        if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
            check({32'h0000_0000, bresp},
                  {32'h0000_0000, bq.pop_front()});
    end

    // ----------------------------------------
    // Watchdog and main sequence
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize();
    end

    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready, ssel_n} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hf;
        want = '0;
        end_a = 14'h3fff;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_st(32'h0000_0000);
        rd(32'h4000_C8F0, {`SDS_RESP_SLVERR, 32'h0000_0000});
        rv = $random(seed) | 32'h0000_0001;
        wr(`SDS_ADDR_TXA_START, rv, `SDS_RESP_OKAY);
        rd(`SDS_ADDR_TXA_START, {2'b00, 18'h0_0000, rv[13:0]});
        check({20'h0_0000, txa_start}, {20'h0_0000, rv[13:0]});
        wr(`SDS_ADDR_CONFIG, 32'h0000_0003, `SDS_RESP_OKAY);
        wr(`SDS_ADDR_CONTROL, 32'h0000_0007, `SDS_RESP_OKAY);
        rd_st(32'h0000_0005);
        pop(4'b1100);
        pop(4'b1010);
        pop(4'b1001);
        repeat (3) @(posedge clk);
        rd_st(32'h0000_0156);
        ss();
        rd_st(32'h0000_0D56);
        check({20'h0_0000, cnt_cap}, {20'h0_0000, 14'h0000});
        ss();
        rd_st(32'h0000_1D56);
        pop(4'b1100);
        rd_st(32'h0000_1F56);
        wr(`SDS_ADDR_STATUS, 32'hFFFF_FFFF, `SDS_RESP_OKAY);
        rd_st(32'h0000_1F56);
        wr(`SDS_ADDR_CONTROL, 32'h0000_0001, `SDS_RESP_OKAY);
        rd_st(32'h0000_0206);
        wr(`SDS_ADDR_CONFIG, 32'h0000_0002, `SDS_RESP_OKAY);
        pop(4'b1110);
        pop(4'b1001);
        rd_st(32'h0000_0226);
        wr(`SDS_ADDR_CONTROL, 32'h0000_0010, `SDS_RESP_OKAY);
        rd_st(32'h0000_0004);
        wr(`SDS_ADDR_CONTROL, 32'h0000_0008, `SDS_RESP_OKAY);
        end_a <= 14'h0000;
        repeat (3) @(posedge clk);
        rd_st(32'h0000_0008);
        summarize();
    end
endmodule
